/* pkg/fblu_defs.vh */
`ifndef FBLU_DEFS_VH
`define FBLU_DEFS_VH

// Register byte offsets on the Avalon-MM slave.
`define FBLU_REG_CTRL       4'h0
`define FBLU_REG_WMASK      4'h4
`define FBLU_REG_STATUS     4'h8
`define FBLU_REG_COUNT      4'hC

// Control register field positions.
`define FBLU_CTRL_EN_BIT    0
`define FBLU_CTRL_FN_LSB    4
`define FBLU_CTRL_FN_MSB    7
`define FBLU_CTRL_FMT_LSB   8
`define FBLU_CTRL_FMT_MSB   10
`define FBLU_CTRL_BLEND_BIT 12

// Reset values.
`define FBLU_CTRL_RESET     32'h00000030
`define FBLU_WMASK_RESET    4'hF

// Component write mask bits.
`define FBLU_WRITE_RED_BIT   4'h1
`define FBLU_WRITE_GREEN_BIT 4'h2
`define FBLU_WRITE_BLUE_BIT  4'h4
`define FBLU_WRITE_ALPHA_BIT 4'h8

// Attachment numeric format classes.
`define FBLU_FMT_UINT       3'h0
`define FBLU_FMT_SINT       3'h1
`define FBLU_FMT_UNORM      3'h2
`define FBLU_FMT_SNORM      3'h3
`define FBLU_FMT_FLOAT      3'h4
`define FBLU_FMT_SRGB       3'h5

// Bitwise function codes.
`define FBLU_FN_ALL_ZERO     4'h0
`define FBLU_FN_AND          4'h1
`define FBLU_FN_S_AND_NOT_D  4'h2
`define FBLU_FN_PASS_SOURCE  4'h3
`define FBLU_FN_NOT_S_AND_D  4'h4
`define FBLU_FN_KEEP_DEST    4'h5
`define FBLU_FN_XOR          4'h6
`define FBLU_FN_OR           4'h7
`define FBLU_FN_NOR          4'h8
`define FBLU_FN_XNOR         4'h9
`define FBLU_FN_NOT_DEST     4'hA
`define FBLU_FN_S_OR_NOT_D   4'hB
`define FBLU_FN_NOT_SOURCE   4'hC
`define FBLU_FN_NOT_S_OR_D   4'hD
`define FBLU_FN_NAND         4'hE
`define FBLU_FN_ALL_ONE      4'hF

`endif

/* rtl/fblu_top.v */
`timescale 1ns/1ps
`include "fblu_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module fblu_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             i_clk,      // Pipeline clock.
    input  wire             i_reset,    // Synchronous reset, active high.
    input  wire             i_valid,    // Write side valid.
    output wire             o_ready,    // Write side ready (not full).
    input  wire [WIDTH-1:0] i_data,     // Write data.
    output wire             o_valid,    // Read side valid (not empty).
    input  wire             i_ready,    // Read side ready.
    output wire [WIDTH-1:0] o_data,     // Read data at head.
    output wire [AW:0]      o_level     // Words held.
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      level_q;
    wire            push;
    wire            pop;

    assign o_ready = (level_q != DEPTH[AW:0]);
    assign o_valid = (level_q != {(AW+1){1'b0}});
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;
    assign o_data  = mem[rd_ptr_q];
    assign o_level = level_q;

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= i_data;
        end
    end

    // Pointers wrap by index compare so DEPTH need not be a power of two.
    always @(posedge i_clk) begin
        if (i_reset) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            level_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= ({1'b0, wr_ptr_q} == DEPTH[AW:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= ({1'b0, rd_ptr_q} == DEPTH[AW:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                level_q <= level_q + 1'b1;
            end else if (pop && !push) begin
                level_q <= level_q - 1'b1;
            end
        end
    end
endmodule // fblu_fifo

////////////////////////////////////////////////////////////////////////////////
module fblu_top #(
    parameter CW    = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire            i_clk,            // Pipeline clock, 25 MHz.
    input  wire            i_reset,          // Synchronous reset, active high.
    input  wire [3:0]      i_avs_address,    // Avalon byte address.
    input  wire            i_avs_read,       // Avalon read request.
    input  wire            i_avs_write,      // Avalon write request.
    input  wire [31:0]     i_avs_writedata,  // Avalon write data.
    input  wire [3:0]      i_avs_byteenable, // Avalon byte enables.
    output reg  [31:0]     o_avs_readdata,   // Avalon read data.
    output wire            o_avs_waitrequest,// Avalon wait request.
    input  wire            i_frag_valid,     // Fragment present.
    output wire            o_frag_ready,     // Fragment accepted.
    input  wire [4*CW-1:0] i_frag_color,     // Fragment colour s, {A,B,G,R}.
    input  wire [4*CW-1:0] i_dest_color,     // Stored colour d, {A,B,G,R}.
    output reg             o_out_valid,      // Result present.
    input  wire            i_out_ready,      // Write stage accepts result.
    output reg  [4*CW-1:0] o_out_color,      // Colour toward write stage.
    output reg  [3:0]      o_out_wmask,      // Component write mask.
    output reg             o_out_blend_en    // Blending enable for this result.
);
    reg  [31:0]     ctrl_q;
    reg  [3:0]      wmask_q;
    reg  [31:0]     count_q;
    reg             ack_q;
    wire            fifo_valid;
    wire [8*CW-1:0] fifo_data;
    wire [AW:0]     fifo_level;
    wire            take;
    wire            combine_en;
    wire [3:0]      fn_sel;
    wire [2:0]      fmt;
    wire            fmt_ok;
    wire [4*CW-1:0] s_val;
    wire [4*CW-1:0] d_val;
    wire [4*CW-1:0] comb_val;
    wire            acc;
    wire [31:0]     wr_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Register slave: every access waits exactly one cycle.
    assign acc               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = acc & ~ack_q;
    assign wr_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    always @(posedge i_clk) begin
        if (i_reset) begin
            ack_q          <= 1'b0;
            ctrl_q         <= `FBLU_CTRL_RESET;
            wmask_q        <= `FBLU_WMASK_RESET;
            o_avs_readdata <= 32'h00000000;
        end else begin
            ack_q <= acc & ~ack_q;
            if (i_avs_write && ack_q) begin
                case (i_avs_address)
                    `FBLU_REG_CTRL: begin
                        ctrl_q <= ((ctrl_q & ~wr_mask) | (i_avs_writedata & wr_mask)) & 32'h000017F1;
                    end
                    `FBLU_REG_WMASK: begin
                        if (i_avs_byteenable[0]) begin
                            wmask_q <= i_avs_writedata[3:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (i_avs_read && !ack_q) begin
                case (i_avs_address)
                    `FBLU_REG_CTRL:   o_avs_readdata <= ctrl_q;
                    `FBLU_REG_WMASK:  o_avs_readdata <= {28'h0000000, wmask_q};
                    `FBLU_REG_STATUS: o_avs_readdata <= {{(31-AW){1'b0}}, fifo_level};
                    `FBLU_REG_COUNT:  o_avs_readdata <= count_q;
                    default:          o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fragments and their stored colour wait together in the FIFO.
    fblu_fifo #(
        .WIDTH (8*CW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_valid (i_frag_valid),
        .o_ready (o_frag_ready),
        .i_data  ({i_dest_color, i_frag_color}),
        .o_valid (fifo_valid),
        .i_ready (take),
        .o_data  (fifo_data),
        .o_level (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Combining stage.
    assign combine_en = ctrl_q[`FBLU_CTRL_EN_BIT];
    assign fn_sel     = ctrl_q[`FBLU_CTRL_FN_MSB:`FBLU_CTRL_FN_LSB];
    assign fmt        = ctrl_q[`FBLU_CTRL_FMT_MSB:`FBLU_CTRL_FMT_LSB];
    assign fmt_ok     = (fmt == `FBLU_FMT_UINT) || (fmt == `FBLU_FMT_SINT) ||
                        (fmt == `FBLU_FMT_UNORM) || (fmt == `FBLU_FMT_SNORM);
    assign s_val      = fifo_data[4*CW-1:0];
    assign d_val      = fifo_data[8*CW-1:4*CW];

    function [CW-1:0] fblu_op;
        input [3:0]    code;
        input [CW-1:0] s;
        input [CW-1:0] d;
        begin
            case (code)
                `FBLU_FN_ALL_ZERO:    fblu_op = {CW{1'b0}};
                `FBLU_FN_AND:         fblu_op = s & d;
                `FBLU_FN_S_AND_NOT_D: fblu_op = s & ~d;
                `FBLU_FN_PASS_SOURCE: fblu_op = s;
                `FBLU_FN_NOT_S_AND_D: fblu_op = ~s & d;
                `FBLU_FN_KEEP_DEST:   fblu_op = d;
                `FBLU_FN_XOR:         fblu_op = s ^ d;
                `FBLU_FN_OR:          fblu_op = s | d;
                `FBLU_FN_NOR:         fblu_op = ~(s | d);
                `FBLU_FN_XNOR:        fblu_op = ~(s ^ d);
                `FBLU_FN_NOT_DEST:    fblu_op = ~d;
                `FBLU_FN_S_OR_NOT_D:  fblu_op = s | ~d;
                `FBLU_FN_NOT_SOURCE:  fblu_op = ~s;
                `FBLU_FN_NOT_S_OR_D:  fblu_op = ~s | d;
                `FBLU_FN_NAND:        fblu_op = ~(s & d);
                default:              fblu_op = {CW{1'b1}};
            endcase
        end
    endfunction

    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_comp
            // Each component is evaluated on its own slice.
            assign comb_val[c*CW +: CW] = fblu_op(fn_sel, s_val[c*CW +: CW], d_val[c*CW +: CW]);
        end
    endgenerate

    // The output register refills from the FIFO whenever it is empty or being drained and the FIFO holds a word.
    assign take = fifo_valid & (~o_out_valid | i_out_ready);

    always @(posedge i_clk) begin
        if (i_reset) begin
            o_out_valid    <= 1'b0;
            o_out_color    <= {(4*CW){1'b0}};
            o_out_wmask    <= 4'h0;
            o_out_blend_en <= 1'b0;
            count_q        <= 32'h00000000;
        end else begin
            if (take) begin
                o_out_valid <= 1'b1;
                o_out_wmask <= wmask_q;
                if (combine_en && fmt_ok) begin
                    o_out_color <= comb_val;
                    count_q     <= count_q + 32'h00000001;
                end else begin
                    o_out_color <= s_val;
                end
                // Enabling the combine overrides the attachment blend setting.
                o_out_blend_en <= ctrl_q[`FBLU_CTRL_BLEND_BIT] & ~combine_en;
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end
endmodule // fblu_top

/* verification/fblu_mem.sv */
`timescale 1ns/1ps
module fblu_mem #(
    parameter CW = 8
) (
    input  wire            i_clk,   // Pipeline clock.
    input  wire            i_stall, // Hold off the write stage.
    input  wire            i_valid, // Result present.
    input  wire [4*CW-1:0] i_color, // Result colour.
    input  wire [3:0]      i_wmask, // Component write mask.
    output wire            o_ready, // Result taken.
    output wire [4*CW-1:0] o_dest   // Stored colour.
);
    reg [4*CW-1:0] mem_q;
    integer        k;
    assign o_ready = !i_stall;
    assign o_dest  = mem_q;
    // Components are written one by one, so a cleared mask bit leaves memory as it was.
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            for (k = 0; k < 4; k = k + 1) begin
                if (i_wmask[k]) begin
                    mem_q[k*CW +: CW] <= i_color[k*CW +: CW];
                end
            end
        end
    end
endmodule // fblu_mem

/* verification/fblu_monitor.sv */
`timescale 1ns/1ps
module fblu_monitor #(
    parameter CW = 8
) (
    input wire            i_clk,             // Pipeline clock.
    input wire            i_reset,           // Synchronous reset.
    input wire            i_avs_read,        // Bus read.
    input wire            i_avs_write,       // Bus write.
    input wire [31:0]     o_avs_readdata,    // Bus read data.
    input wire            o_avs_waitrequest, // Bus wait.
    input wire            o_frag_ready,      // Fragment accepted.
    input wire            o_out_valid,       // Result present.
    input wire            i_out_ready,       // Write stage ready.
    input wire [4*CW-1:0] o_out_color,       // Result colour.
    input wire [3:0]      o_out_wmask,       // Result mask.
    input wire            o_out_blend_en     // Result blend enable.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_ack;
        (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    endsequence
    chk_bus_answer: assert property (s_req |=> s_ack)
        else $error("bus answer late");
    chk_bus_once: assert property (s_ack |=> !(i_avs_read || i_avs_write) || o_avs_waitrequest)
        else $error("bus answered twice");
    chk_bus_idle: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait without request");
    chk_out_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_color)
        && $stable(o_out_wmask) && $stable(o_out_blend_en)) else $error("result changed while stalled");
    chk_rst_outs: assert property ($fell(i_reset) |-> o_avs_readdata == 32'h00000000 && !o_out_valid
        && o_out_wmask == 4'h0 && !o_out_blend_en) else $error("outputs not cleared by reset");
    chk_rst_ready: assert property ($fell(i_reset) |-> o_frag_ready)
        else $error("input not ready after reset");
    chk_full_out: assert property (!o_frag_ready |-> o_out_valid)
        else $error("full buffer with empty output");
    chk_drain_next: assert property (o_out_valid && i_out_ready && !o_frag_ready |=> o_out_valid)
        else $error("buffered result not forwarded");
endmodule // fblu_monitor

/* verification/framebuffer_bitwise_logic_unit_test.sv */
`timescale 1ns/1ps
`include "fblu_defs.vh"
module framebuffer_bitwise_logic_unit_test;
    localparam [31:0] D0 = 32'h0FF05AC3;
    localparam [31:0] S0 = 32'h33CC96A5;
    reg         i_clk = 1'b0;
    reg         i_reset = 1'b1;
    reg  [3:0]  i_avs_address = 4'h0;
    reg         i_avs_read = 1'b0;
    reg         i_avs_write = 1'b0;
    reg  [31:0] i_avs_writedata = 32'h00000000;
    reg         i_frag_valid = 1'b0;
    reg  [31:0] i_frag_color = 32'h00000000;
    reg         stall = 1'b0;
    wire [31:0] o_avs_readdata, o_out_color, dest;
    wire        o_avs_waitrequest, o_frag_ready, o_out_valid, out_ready, o_out_blend_en;
    wire [3:0]  o_out_wmask;
    integer     err_total = 0, comparisons = 0, cyc = 0, i, n;
    reg  [31:0] got, go;
    reg  [3:0]  gm;
    reg         gb;
    fblu_top DUT (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_frag_valid(i_frag_valid),
        .o_frag_ready(o_frag_ready), .i_frag_color(i_frag_color), .i_dest_color(dest), .o_out_valid(o_out_valid),
        .i_out_ready(out_ready), .o_out_color(o_out_color), .o_out_wmask(o_out_wmask),
        .o_out_blend_en(o_out_blend_en));
    fblu_mem u_mem (.i_clk(i_clk), .i_stall(stall), .i_valid(o_out_valid), .i_color(o_out_color),
        .i_wmask(o_out_wmask), .o_ready(out_ready), .o_dest(dest));
    always #20 i_clk = ~i_clk;
    ////////////////////////////////////////
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            test_done;
        end
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Called just after a rising edge; one idle edge follows so the next call never re-raises a strobe at once.
    task bus(input rd, input [3:0] a, input [31:0] wd);
        begin
            i_avs_address <= a;
            i_avs_writedata <= wd;
            i_avs_read <= rd;
            i_avs_write <= !rd;
            @(posedge i_clk);
            while (o_avs_waitrequest) @(posedge i_clk);
            got = o_avs_readdata;
            i_avs_read <= 1'b0;
            i_avs_write <= 1'b0;
            @(posedge i_clk);
        end
    endtask
    // Returns one edge after the result is taken, so the memory model already holds the write.
    task frag(input [31:0] sv);
        begin
            i_frag_valid <= 1'b1;
            i_frag_color <= sv;
            @(posedge i_clk);
            while (!o_frag_ready) @(posedge i_clk);
            i_frag_valid <= 1'b0;
            @(posedge i_clk);
            while (!o_out_valid) @(posedge i_clk);
            go = o_out_color;
            gb = o_out_blend_en;
            gm = o_out_wmask;
            @(posedge i_clk);
        end
    endtask
    function [31:0] ctl(input en, input [3:0] fn, input [2:0] fm, input bl);
        ctl = {19'h0, bl, 1'b0, fm, fn, 3'h0, en};
    endfunction
    function [31:0] fx(input [3:0] c, input [31:0] a, input [31:0] b);
        case (c)
            4'h0: fx = 32'h00000000;
            4'h1: fx = a & b;
            4'h2: fx = a & ~b;
            4'h3: fx = a;
            4'h4: fx = ~a & b;
            4'h5: fx = b;
            4'h6: fx = a ^ b;
            4'h7: fx = a | b;
            4'h8: fx = ~(a | b);
            4'h9: fx = ~(a ^ b);
            4'hA: fx = ~b;
            4'hB: fx = a | ~b;
            4'hC: fx = ~a;
            4'hD: fx = ~a | b;
            4'hE: fx = ~(a & b);
            default: fx = 32'hFFFFFFFF;
        endcase
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        bus(1'b1, `FBLU_REG_CTRL, 32'h0);
        chk("ctrl", `FBLU_CTRL_RESET, got);
        bus(1'b1, `FBLU_REG_WMASK, 32'h0);
        chk("wmask", 32'h0000000F, got);
        bus(1'b0, 4'h1, 32'hFFFFFFFF);
        bus(1'b1, 4'h1, 32'h0);
        chk("unmapped", 32'h0, got);
        for (i = 0; i < 16; i = i + 1) begin
            bus(1'b0, `FBLU_REG_CTRL, ctl(1'b1, i[3:0], `FBLU_FMT_UINT, 1'b1));
            u_mem.mem_q <= D0;
            frag(S0);
            chk("function", fx(i[3:0], S0, D0), go);
            chk("blend", 32'h0, {31'h0, gb});
        end
        for (i = 0; i < 6; i = i + 1) begin
            bus(1'b0, `FBLU_REG_CTRL, ctl(1'b1, `FBLU_FN_XOR, i[2:0], 1'b1));
            u_mem.mem_q <= D0;
            frag(S0);
            chk("format", (i < 4) ? S0 ^ D0 : S0, go);
            chk("blend", 32'h0, {31'h0, gb});
        end
        bus(1'b0, `FBLU_REG_CTRL, ctl(1'b0, `FBLU_FN_ALL_ONE, `FBLU_FMT_UINT, 1'b1));
        frag(S0);
        chk("disabled", S0, go);
        chk("blend", 32'h1, {31'h0, gb});
        bus(1'b0, `FBLU_REG_WMASK, 32'h00000005);
        bus(1'b0, `FBLU_REG_CTRL, ctl(1'b1, `FBLU_FN_ALL_ONE, `FBLU_FMT_UINT, 1'b0));
        u_mem.mem_q <= D0;
        frag(S0);
        chk("mask", 32'h5, {28'h0, gm});
        chk("memory", 32'h0FFF5AFF, u_mem.mem_q);
        // Sixteen buffered words plus the one held in the output register.
        stall <= 1'b1;
        i_frag_valid <= 1'b1;
        n = 0;
        @(posedge i_clk);
        while (o_frag_ready && n < 40) begin
            n = n + 1;
            @(posedge i_clk);
        end
        i_frag_valid <= 1'b0;
        chk("accepted", 32'd17, n);
        bus(1'b1, `FBLU_REG_STATUS, 32'h0);
        chk("level", 32'd16, got);
        stall <= 1'b0;
        @(posedge i_clk);
        while (o_out_valid) @(posedge i_clk);
        bus(1'b1, `FBLU_REG_STATUS, 32'h0);
        chk("level", 32'd0, got);
        bus(1'b1, `FBLU_REG_COUNT, 32'h0);
        chk("combined", 32'd38, got);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        bus(1'b1, `FBLU_REG_CTRL, 32'h0);
        chk("ctrl", `FBLU_CTRL_RESET, got);
        test_done;
    end
endmodule // framebuffer_bitwise_logic_unit_test
bind fblu_top fblu_monitor #(.CW(CW)) u_mon (.i_clk(i_clk), .i_reset(i_reset), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_frag_ready(o_frag_ready), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_out_color(o_out_color), .o_out_wmask(o_out_wmask), .o_out_blend_en(o_out_blend_en));
